/* include/fzc_consts.svh */
// offsets, field positions, reset values and timing for the fan zone and coefficient registers
`ifndef FZC_CONSTS_SVH
`define FZC_CONSTS_SVH
`define FZC_ADDR_MAX_TEMP 8'h78
`define FZC_ADDR_GAIN_HI 8'h79
`define FZC_ADDR_GAIN_LO_OFFS_HI 8'h7A
`define FZC_ADDR_OFFS_LO_SPIN 8'h7B
`define FZC_ADDR_ZONE_FAN12 8'h7C
`define FZC_ADDR_ZONE_FAN34 8'h7D
`define FZC_REG_RESET 8'h00
`define FZC_GAIN_LO_MSB 7
`define FZC_GAIN_LO_LSB 6
`define FZC_OFFS_HI_MSB 5
`define FZC_OFFS_HI_LSB 0
`define FZC_OFFS_LO_MSB 7
`define FZC_OFFS_LO_LSB 5
`define FZC_SPIN_MSB 2
`define FZC_SPIN_LSB 0
`define FZC_FAN1_SEL_MSB 7
`define FZC_FAN1_SEL_LSB 4
`define FZC_FAN2_SEL_MSB 3
`define FZC_FAN2_SEL_LSB 0
`define FZC_ZONE_MAX 4'h0
`define FZC_ZONE_LAST 4'hA
`define FZC_CLK_KHZ 25000
`define FZC_SPIN_T1_MS 100
`define FZC_SPIN_T2_MS 250
`define FZC_SPIN_T3_MS 400
`define FZC_SPIN_T4_MS 667
`define FZC_SPIN_T5_MS 1000
`define FZC_SPIN_T6_MS 2000
`define FZC_SPIN_T7_MS 4000
`define FZC_DEF_GAIN 10'h200
`define FZC_DEF_OFFS 9'h000
`endif

/* include/fzc_pkg.sv */
// types shared by the fan zone and coefficient register group
package fzc_pkg;
  typedef logic [7:0] fzc_temp_t;
  typedef logic [9:0] fzc_gain_t;
  typedef logic [8:0] fzc_offs_t;
  typedef enum logic [1:0] {
    FZC_IDLE = 2'b00,
    FZC_SPIN = 2'b01,
    FZC_RUN = 2'b11
  } fzc_fan_state_t;
endpackage

/* rtl/fzc_regs.sv */
// fan zone select, optional coefficient and highest temperature registers
`include "fzc_consts.svh"
module fzc_regs #(
  parameter int unsigned CYC_PER_MS = `FZC_CLK_KHZ
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port from the management bus engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // decoded temperatures
  input wire fzc_pkg::fzc_temp_t [9:0] temp_reading,
  input wire logic temp_valid,
  input wire logic [9:0] coef_sel,
  // per-channel coefficients
  output fzc_pkg::fzc_gain_t [9:0] chan_gain,
  output fzc_pkg::fzc_offs_t [9:0] chan_offset,
  // fan control
  input wire logic [1:0] fan_start,
  input wire logic [1:0] fan_stop,
  output logic [1:0] fan_spinup,
  output logic [1:0] fan_running,
  output fzc_pkg::fzc_temp_t [1:0] fan_ctrl_temp
);
  import fzc_pkg::*;

  localparam int unsigned MS_CYC = CYC_PER_MS * (`FZC_CLK_KHZ / 1000) / 25;

  fzc_temp_t highest_remote_temp;
  logic [7:0] gain_coef_high;
  logic [7:0] gain_low_offset_high;
  logic [7:0] offset_low_spinup;
  logic [7:0] fan12_zone_select;
  logic [7:0] fan34_zone_select;
  fzc_temp_t next_highest;
  logic [7:0] next_gain_hi;
  logic [7:0] next_gain_lo;
  logic [7:0] next_offs_lo;
  logic [7:0] next_zone12;
  logic [7:0] next_zone34;
  logic [7:0] next_rdata;
  fzc_temp_t max_now;
  fzc_gain_t optional_gain_coef;
  fzc_offs_t optional_offset_coef;
  logic [2:0] fan_spinup_time;
  logic [3:0] fan1_zone_sel;
  logic [3:0] fan2_zone_sel;

  function automatic fzc_temp_t max_of(input fzc_temp_t [9:0] t);
    fzc_temp_t m;
    m = t[0];
    for (int i = 1; i < 10; i++) begin
      if (t[i] > m) m = t[i];
    end
    return m;
  endfunction

  // out-of-range codes are treated as reserved and follow the maximum
  function automatic fzc_temp_t zone_pick(input logic [3:0] sel, input fzc_temp_t mx,
                                          input fzc_temp_t [9:0] t);
    if (sel == `FZC_ZONE_MAX || sel > `FZC_ZONE_LAST) return mx;
    return t[sel - 4'h1];
  endfunction

  function automatic logic [26:0] spin_cycles(input logic [2:0] code);
    int unsigned ms;
    unique case (code)
      3'h1: ms = `FZC_SPIN_T1_MS;
      3'h2: ms = `FZC_SPIN_T2_MS;
      3'h3: ms = `FZC_SPIN_T3_MS;
      3'h4: ms = `FZC_SPIN_T4_MS;
      3'h5: ms = `FZC_SPIN_T5_MS;
      3'h6: ms = `FZC_SPIN_T6_MS;
      3'h7: ms = `FZC_SPIN_T7_MS;
      3'h0: ms = 0;
    endcase
    return 27'(ms * MS_CYC);
  endfunction

  assign max_now = max_of(temp_reading);
  assign optional_gain_coef = {gain_coef_high,
    gain_low_offset_high[`FZC_GAIN_LO_MSB:`FZC_GAIN_LO_LSB]};
  assign optional_offset_coef = {gain_low_offset_high[`FZC_OFFS_HI_MSB:`FZC_OFFS_HI_LSB],
    offset_low_spinup[`FZC_OFFS_LO_MSB:`FZC_OFFS_LO_LSB]};
  assign fan_spinup_time = offset_low_spinup[`FZC_SPIN_MSB:`FZC_SPIN_LSB];
  assign fan1_zone_sel = fan12_zone_select[`FZC_FAN1_SEL_MSB:`FZC_FAN1_SEL_LSB];
  assign fan2_zone_sel = fan12_zone_select[`FZC_FAN2_SEL_MSB:`FZC_FAN2_SEL_LSB];
  assign reg_hit = reg_addr >= `FZC_ADDR_MAX_TEMP && reg_addr <= `FZC_ADDR_ZONE_FAN34;

  // register file
  always_comb begin
    next_highest = temp_valid ? max_now : highest_remote_temp;
    next_gain_hi = gain_coef_high;
    next_gain_lo = gain_low_offset_high;
    next_offs_lo = offset_low_spinup;
    next_zone12 = fan12_zone_select;
    next_zone34 = fan34_zone_select;
    if (reg_wr) begin
      unique case (reg_addr)
        `FZC_ADDR_GAIN_HI: next_gain_hi = reg_wdata;
        `FZC_ADDR_GAIN_LO_OFFS_HI: next_gain_lo = reg_wdata;
        `FZC_ADDR_OFFS_LO_SPIN: next_offs_lo = reg_wdata;
        `FZC_ADDR_ZONE_FAN12: next_zone12 = reg_wdata;
        `FZC_ADDR_ZONE_FAN34: next_zone34 = reg_wdata;
        default: ; // the maximum register ignores writes
      endcase
    end
    next_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        `FZC_ADDR_MAX_TEMP: next_rdata = highest_remote_temp;
        `FZC_ADDR_GAIN_HI: next_rdata = gain_coef_high;
        `FZC_ADDR_GAIN_LO_OFFS_HI: next_rdata = gain_low_offset_high;
        `FZC_ADDR_OFFS_LO_SPIN: next_rdata = offset_low_spinup;
        `FZC_ADDR_ZONE_FAN12: next_rdata = fan12_zone_select;
        `FZC_ADDR_ZONE_FAN34: next_rdata = fan34_zone_select;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      highest_remote_temp <= `FZC_REG_RESET;
      gain_coef_high <= `FZC_REG_RESET;
      gain_low_offset_high <= `FZC_REG_RESET;
      offset_low_spinup <= `FZC_REG_RESET;
      fan12_zone_select <= `FZC_REG_RESET;
      fan34_zone_select <= `FZC_REG_RESET;
      reg_rdata <= 8'h00;
    end else begin
      highest_remote_temp <= next_highest;
      gain_coef_high <= next_gain_hi;
      gain_low_offset_high <= next_gain_lo;
      offset_low_spinup <= next_offs_lo;
      fan12_zone_select <= next_zone12;
      fan34_zone_select <= next_zone34;
      reg_rdata <= next_rdata;
    end
  end

  // per-channel coefficients and fan source temperatures
  fzc_gain_t [9:0] next_chan_gain;
  fzc_offs_t [9:0] next_chan_offset;
  fzc_temp_t [1:0] next_ctrl_temp;

  always_comb begin
    for (int i = 0; i < 10; i++) begin
      next_chan_gain[i] = coef_sel[i] ? optional_gain_coef : `FZC_DEF_GAIN;
      next_chan_offset[i] = coef_sel[i] ? optional_offset_coef : `FZC_DEF_OFFS;
    end
    next_ctrl_temp[0] = zone_pick(fan1_zone_sel, highest_remote_temp, temp_reading);
    next_ctrl_temp[1] = zone_pick(fan2_zone_sel, highest_remote_temp, temp_reading);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      chan_gain <= '0;
      chan_offset <= '0;
      fan_ctrl_temp <= '0;
    end else begin
      chan_gain <= next_chan_gain;
      chan_offset <= next_chan_offset;
      fan_ctrl_temp <= next_ctrl_temp;
    end
  end

  // spin-up sequencer per fan; the duration is latched at start so a rewrite
  // of the field mid spin-up does not stretch or cut the running one
  fzc_fan_state_t [1:0] fan_state;
  fzc_fan_state_t [1:0] next_fan_state;
  logic [1:0][26:0] spin_cnt;
  logic [1:0][26:0] next_spin_cnt;

  always_comb begin
    for (int f = 0; f < 2; f++) begin
      next_fan_state[f] = fan_state[f];
      next_spin_cnt[f] = spin_cnt[f];
      unique case (fan_state[f])
        FZC_IDLE: begin
          if (fan_start[f]) begin
            if (fan_spinup_time == 3'h0) begin
              next_fan_state[f] = FZC_RUN;
            end else begin
              next_fan_state[f] = FZC_SPIN;
              next_spin_cnt[f] = spin_cycles(fan_spinup_time) - 27'd1;
            end
          end
        end
        FZC_SPIN: begin
          if (spin_cnt[f] == 27'd0) next_fan_state[f] = FZC_RUN;
          else next_spin_cnt[f] = spin_cnt[f] - 27'd1;
        end
        FZC_RUN: ;
        default: next_fan_state[f] = FZC_IDLE;
      endcase
      if (fan_stop[f]) next_fan_state[f] = FZC_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      fan_state <= '{FZC_IDLE, FZC_IDLE};
      spin_cnt <= '0;
    end else begin
      fan_state <= next_fan_state;
      spin_cnt <= next_spin_cnt;
    end
  end

  for (genvar f = 0; f < 2; f++) begin : g_fan_out
    assign fan_spinup[f] = fan_state[f] == FZC_SPIN;
    assign fan_running[f] = fan_state[f] == FZC_RUN;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_MAX_UPDATE: assert property (temp_valid |=> highest_remote_temp == $past(max_now))
    else $error("max register did not follow the hottest channel");
  AST_MAX_HOLD: assert property (!temp_valid |=> $stable(highest_remote_temp))
    else $error("max register changed without a measurement");
  AST_GAIN_HIGH: assert property (reg_wr && reg_addr == `FZC_ADDR_GAIN_HI
    |=> optional_gain_coef[9:2] == $past(reg_wdata))
    else $error("gain bits 9:2 not taken from the write");
  AST_GAIN_LOW_OFFS: assert property (reg_wr && reg_addr == `FZC_ADDR_GAIN_LO_OFFS_HI
    |=> optional_gain_coef[1:0] == $past(reg_wdata[7:6])
    && optional_offset_coef[8:3] == $past(reg_wdata[5:0]))
    else $error("low gain or high offset bits misplaced");
  AST_OFFS_LOW: assert property (reg_wr && reg_addr == `FZC_ADDR_OFFS_LO_SPIN
    |=> optional_offset_coef[2:0] == $past(reg_wdata[7:5]))
    else $error("low offset bits misplaced");
  AST_NO_SPIN: assert property (fan_state[0] == FZC_IDLE && fan_start[0]
    && !fan_stop[0] && fan_spinup_time == 3'h0 |=> fan_running[0] && !fan_spinup[0])
    else $error("spin-up phase entered with code 000");
  AST_SPIN_ENTER: assert property (fan_state[0] == FZC_IDLE && fan_start[0]
    && !fan_stop[0] && fan_spinup_time != 3'h0 |=> fan_spinup[0]
    && spin_cnt[0] == $past(spin_cycles(fan_spinup_time)) - 27'd1)
    else $error("spin-up not loaded with the coded duration");
  AST_SPIN_END: assert property (fan_spinup[0] && spin_cnt[0] == 27'd0 && !fan_stop[0]
    |=> fan_running[0])
    else $error("spin-up did not end at terminal count");
  AST_ZONE_MAX: assert property ((fan1_zone_sel == 4'h0 || fan1_zone_sel > 4'hA)
    |=> fan_ctrl_temp[0] == $past(highest_remote_temp))
    else $error("fan 1 did not use the maximum temperature");
  AST_ZONE_CHAN: assert property (fan2_zone_sel inside {[4'h1:4'hA]}
    |=> fan_ctrl_temp[1] == $past(temp_reading[fan2_zone_sel - 4'h1]))
    else $error("fan 2 used the wrong channel");
  AST_COEF_SEL: assert property (coef_sel[3]
    |=> chan_gain[3] == $past(optional_gain_coef))
    else $error("channel 3 ignored its optional coefficient select");
  AST_RESET_ZERO: assert property (disable iff (1'b0) !resetn
    |=> fan12_zone_select == 8'h00
    && highest_remote_temp == 8'h00 && offset_low_spinup == 8'h00)
    else $error("registers not zero after reset");

  COV_SPIN: cover property (fan_spinup[0] ##1 fan_running[0]);
  COV_ZONE_CH10: cover property (fan1_zone_sel == 4'hA);
  COV_MAX_READ: cover property (reg_rd && reg_addr == `FZC_ADDR_MAX_TEMP && temp_valid);
endmodule // fzc_regs

/* test/fzc_host.sv */
// register port driver standing in for the management bus engine
module fzc_host (
  // clock
  input wire logic clock,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one-cycle write strobe; data inverted afterwards so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // read data is registered at the strobe edge, so it is taken just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule // fzc_host

/* test/testbench.sv */
// self-checking bench for the fan zone and coefficient registers
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fzc_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mx, d;
  logic reg_wr, reg_rd, reg_hit, temp_valid = 1'b0;
  fzc_temp_t [9:0] temp_reading;
  logic [9:0] coef_sel = 10'h000;
  fzc_gain_t [9:0] chan_gain;
  fzc_offs_t [9:0] chan_offset;
  logic [1:0] fan_start = 2'b00, fan_stop = 2'b00, fan_spinup, fan_running;
  fzc_temp_t [1:0] fan_ctrl_temp;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  int ms[8] = '{0, 100, 250, 400, 667, 1000, 2000, 4000};
  always #20 clock = ~clock;
  fzc_host fzc_host_i (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // one cycle per millisecond keeps the longest spin-up at 4000 cycles
  fzc_regs #(.CYC_PER_MS(1)) fzc_regs_i (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .temp_reading(temp_reading),
    .temp_valid(temp_valid), .coef_sel(coef_sel), .chan_gain(chan_gain),
    .chan_offset(chan_offset), .fan_start(fan_start), .fan_stop(fan_stop),
    .fan_spinup(fan_spinup), .fan_running(fan_running), .fan_ctrl_temp(fan_ctrl_temp));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    fzc_host_i.rd(a, v);
    chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, v});
  endtask
  // drives the bench's own start or stop lines directly; a copied argument would never reach them
  task automatic pulse(input bit stop, input logic [1:0] v);
    @(posedge clock);
    #1;
    if (stop) fan_stop = v;
    else fan_start = v;
    @(posedge clock);
    #1;
    fan_start = 2'b00;
    fan_stop = 2'b00;
  endtask
  task automatic spin(input int f, input int k);
    fzc_host_i.wr(8'h7B, 8'(k));
    pulse(1'b0, 2'(1 << f));
    n = 0;
    while (fan_spinup[f] === 1'b1 && n < 5000) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("spinup cycles", 16'(ms[k]), 16'(n));
    chk("running", 16'(1 << f), {14'h0, fan_running});
    pulse(1'b1, 2'(1 << f));
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    n_errors++;
    give_verdict();
  end
  initial begin
    mx = 8'h00;
    for (int i = 0; i < 10; i++) begin
      temp_reading[i] = 8'h30 + 8'(i * 5);
    end
    temp_reading[4] = 8'h7A;
    for (int i = 0; i < 10; i++) begin
      if (temp_reading[i] > mx) mx = temp_reading[i];
    end
    repeat (4) @(posedge clock);
    #1;
    resetn = 1'b1;
    for (int a = 8'h77; a <= 8'h7E; a++) begin
      rchk(8'(a), 8'h00);
      chk("reg_hit", 16'(a >= 8'h78 && a <= 8'h7D), {15'h0, reg_hit});
    end
    $display("test reset_values done");
    for (int a = 8'h79; a <= 8'h7D; a++) fzc_host_i.wr(8'(a), 8'h5A ^ 8'(a));
    for (int a = 8'h79; a <= 8'h7D; a++) rchk(8'(a), 8'h5A ^ 8'(a));
    $display("test readback done");
    for (int p = 0; p < 2; p++) begin
      // second pass cools the hottest channel, so the maximum has to fall
      if (p == 1) begin
        temp_reading[4] = 8'h70;
        mx = 8'h70;
      end
      @(posedge clock);
      #1;
      temp_valid = 1'b1;
      @(posedge clock);
      #1;
      temp_valid = 1'b0;
      fzc_host_i.wr(8'h78, 8'h11);
      rchk(8'h78, mx);
    end
    $display("test max_temp done");
    fzc_host_i.wr(8'h79, 8'hB6);
    fzc_host_i.wr(8'h7A, 8'hC5);
    fzc_host_i.wr(8'h7B, 8'hA0);
    coef_sel = 10'h009;
    repeat (2) @(posedge clock);
    #1;
    chk("gain0", 16'h02DB, 16'(chan_gain[0]));
    chk("offs0", 16'h002D, 16'(chan_offset[0]));
    chk("gain3", 16'h02DB, 16'(chan_gain[3]));
    chk("gain1", 16'h0200, 16'(chan_gain[1]));
    chk("offs1", 16'h0000, 16'(chan_offset[1]));
    $display("test coefficients done");
    // every code on both fans, fan 2 getting the mirror code
    for (int c = 0; c < 16; c++) begin
      fzc_host_i.wr(8'h7C, {4'(c), 4'(15 - c)});
      repeat (2) @(posedge clock);
      #1;
      d = (c >= 1 && c <= 10) ? temp_reading[c - 1] : mx;
      chk("fan1 temp", {8'h00, d}, {8'h00, fan_ctrl_temp[0]});
      d = (15 - c >= 1 && 15 - c <= 10) ? temp_reading[14 - c] : mx;
      chk("fan2 temp", {8'h00, d}, {8'h00, fan_ctrl_temp[1]});
    end
    $display("test zone_select done");
    for (int k = 0; k < 8; k++) spin(0, k);
    spin(1, 1);
    $display("test spinup done");
    @(posedge clock);
    #1;
    resetn = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    resetn = 1'b1;
    rchk(8'h78, 8'h00);
    rchk(8'h7A, 8'h00);
    rchk(8'h7C, 8'h00);
    $display("test mid_reset done");
    give_verdict();
  end
endmodule // testbench
